/* File: verilog/cfg_port_pkg.sv */
// constants, field layout and carrier types of the three-wire configuration port
package cfg_port_pkg;

   // frame and address layout
   localparam int FRAME_W = 16;
   localparam int ADDR_W  = 4;
   localparam int NUM_REGS = 16;

   // register addresses (the low nibble of every frame)
   localparam logic [3:0] ADDR_STATUS   = 4'h0;
   localparam logic [3:0] ADDR_VCO      = 4'h3;
   localparam logic [3:0] ADDR_MODE     = 4'h5;
   localparam logic [3:0] ADDR_SYNTH_HI = 4'h7;
   localparam logic [3:0] ADDR_OSC      = 4'hb;
   localparam logic [3:0] ADDR_TEST     = 4'hd;
   localparam logic [3:0] ADDR_SYNTH_LO = 4'hf;

   // one bit per address that accepts a write: 3, 5, 7, 11, 13, 15
   localparam logic [15:0] WRITABLE_MASK = 16'ha8a8;
   localparam logic [15:0] REG_RESET     = 16'h0000;
   // bits 9..4 of the mode register, cleared by the clock-plus-latch condition
   localparam logic [15:0] MODE_CLEAR_MASK = 16'h03f0;

   // synthesizer low word: program count bits 6..0, swallow count
   localparam int SL_PROG_LSB    = 9;
   localparam int SL_SWALLOW_LSB = 4;
   // synthesizer high word: program count bits 9..7, reference divider
   localparam int SH_PROG_LSB    = 12;
   localparam int SH_REF_LSB     = 4;
   // oscillator word
   localparam int OSC_POL_BIT    = 14;
   // vco word
   localparam int VCO_WIN_LSB    = 13;
   localparam int VCO_POWER_BIT  = 10;
   localparam int VCO_PUMP_LSB   = 7;
   // mode word
   localparam int MODE_SRC_LSB   = 9;
   localparam int MODE_EXT_BIT   = 6;
   localparam int MODE_CODE_LSB  = 4;

   // status word
   localparam int         STATUS_SEL_BIT = 6;
   localparam int         STATUS_LSB     = 4;
   localparam logic [3:0] STATUS_BITS    = 4'hc;
   localparam logic [1:0] SRC_ERROR      = 2'b10;
   localparam logic [1:0] SRC_BATTERY    = 2'b11;

   // pin synchroniser bit positions
   localparam int SYNC_W    = 8;
   localparam int IDX_SCLK  = 7;
   localparam int IDX_LATCH = 6;
   localparam int IDX_MHIGH = 5;
   localparam int IDX_MLOW  = 4;
   localparam int IDX_ERR   = 3;
   localparam int IDX_BATLO = 2;
   localparam int IDX_LOCK  = 1;
   localparam int IDX_TXD   = 0;

   typedef logic [FRAME_W-1:0] frame_type;

   typedef enum logic [1:0] {
      MODE_SLEEP    = 2'b00,
      MODE_STANDBY  = 2'b01,
      MODE_TRANSMIT = 2'b10,
      MODE_RESERVED = 2'b11
   } op_mode_type;

   typedef enum logic {
      PORT_WRITE = 1'b0,
      PORT_READ  = 1'b1
   } port_state_type;

   typedef struct packed {
      logic [9:0] program_count;
      logic [4:0] swallow_count;
      logic [7:0] ref_divider;
   } synth_cfg_type;

   typedef struct packed {
      logic       data_polarity;
      logic [2:0] tuning_window_select;
      logic       output_power_select;
      logic [1:0] pump_current_select;
   } rf_cfg_type;

   typedef struct packed {
      logic system_error;
      logic battery_low;
      logic pll_locked;
   } analog_status_type;

endpackage : cfg_port_pkg

/* File: verilog/frame_shifter.sv */
// serial-clock-domain input shift register of the configuration port
`timescale 1ns/1ps

module frame_shifter (
   // link side
   input  wire logic               serial_clk,
   input  wire logic               rst_n,
   input  wire logic               latch,
   input  wire logic               data_in,
   // captured frame, stable while latch is high
   output cfg_port_pkg::frame_type word
);
   import cfg_port_pkg::*;

   frame_type shift_r;
   frame_type shift_nxt;

   // msb arrives first, so every new bit enters at the bottom
   always_comb begin
      shift_nxt = shift_r;
      if (!latch) begin
         shift_nxt = {shift_r[FRAME_W-2:0], data_in}; // see [RQ2]
      end
   end

   // every rising link clock edge with latch low shifts, inside a frame or not, status reads included
   always_ff @(posedge serial_clk or negedge rst_n) begin
      if (!rst_n) begin
         shift_r <= REG_RESET;
      end else begin
         shift_r <= shift_nxt;
      end
   end

   assign word = shift_r;

endmodule : frame_shifter

/* File: verilog/config_port.sv */
// three-wire configuration port with write-only register bank and status readback
`timescale 1ns/1ps

// Functional notes
// [RQ1] clock and latch high together clear mode register bits nine down to four
// [RQ2] latch low: data shifts in on rising serial clock, most significant first
// [RQ3] latch rise after last bit loads the frame into register at its low nibble
// [RQ4] all registers are write-only; status alone is readable and never written
// [RQ5] latching address zero enters read mode and shifts status out on data line
// [RQ6] after twelve status bits the port returns to write mode on its own
// [RQ7] address fifteen: program count low seven bits 15..9, swallow count 8..4
// [RQ8] address seven: program count high bits 14..12, reference divider 11..4
// [RQ9] controller keeps reference divider between two and two hundred fifty-five
// [RQ10] output equals crystal times (32 program plus swallow) over divider
// [RQ11] address eleven bit 14 sets data polarity: zero inverts, one passes
// [RQ12] controller writes zero to the reserved oscillator fields
// [RQ13] address three bits 15..13 pick tuning window, higher code narrower
// [RQ14] vco bit ten picks output power: zero low, one high
// [RQ15] two low pump bits set current linearly; upper pump bit written zero
// [RQ16] controller writes four and zero to reserved vco fields
// [RQ17] controller writes one to test register bits 15..13
// [RQ18] mode bits 10..9 pick status bit six source: error, battery, lock
// [RQ19] controller writes mode bit seven as one
// [RQ20] mode bit six: zero takes mode from pins, one from internal field
// [RQ21] internal code: 00 sleep, 01 standby, 10 transmit, 11 reserved
// [RQ22] status six reads one for error, normal supply, lock; bits 3..0 zero
// [RQ23] mode pins decode as 00 sleep, 01 standby, 10 transmit, 11 reserved
// [RQ24] data line is input while writing, open drain output while reading
// [RQ25] controller resets device by holding clock and latch high over 1 us
// [RQ26] frames are sixteen bits with the address in the last four bits
module config_port (
   // system
   input  wire logic                        SYS_CLK,
   input  wire logic                        RSTN,
   // three-wire serial link
   input  wire logic                        SPI_CLOCK,
   input  wire logic                        SPI_LATCH,
   input  wire logic                        SPI_DATA_IN,
   output logic                             SPI_DATA_OUT,
   output logic                             SPI_DATA_OE_N,
   // external mode pins
   input  wire logic                        MODE_PIN_HIGH,
   input  wire logic                        MODE_PIN_LOW,
   // analog status indications
   input  cfg_port_pkg::analog_status_type  ANALOG_STATUS,
   // transmit data path
   input  wire logic                        TX_DATA_IN,
   output logic                             MOD_DATA_OUT,
   // configuration towards the analog blocks
   output cfg_port_pkg::synth_cfg_type      SYNTH_CFG,
   output cfg_port_pkg::rf_cfg_type         RF_CFG,
   output cfg_port_pkg::op_mode_type        OP_MODE,
   output logic                             OSC_ENABLE,
   output logic                             TX_ENABLE
);
   import cfg_port_pkg::*;

   // link-domain shift register
   frame_type         shift_word;

   // pin synchronisers
   logic [SYNC_W-1:0] pin_raw;
   logic [SYNC_W-1:0] meta_r;
   logic [SYNC_W-1:0] meta_nxt;
   logic [SYNC_W-1:0] sync_r;
   logic [SYNC_W-1:0] sync_nxt;
   logic [1:0]        hist_r;
   logic [1:0]        hist_nxt;

   // decoded link events
   logic              sclk_lvl;
   logic              latch_lvl;
   logic              latch_rise;
   logic              sclk_rise;
   logic              part_rst;
   logic              commit;
   logic [ADDR_W-1:0] frame_addr;
   frame_type         frame_word;

   // register bank
   frame_type         regs_r   [NUM_REGS];
   frame_type         regs_nxt [NUM_REGS];

   // readback
   port_state_type    state_r;
   port_state_type    state_nxt;
   logic [3:0]        bits_left_r;
   logic [3:0]        bits_left_nxt;
   logic [11:0]       status_sh_r;
   logic [11:0]       status_sh_nxt;
   logic              status_sel;
   frame_type         status_word;
   logic              oe_n_r;
   logic              oe_n_nxt;
   logic              data_out_r;
   logic              data_out_nxt;

   // configuration outputs
   logic [1:0]        src_code;
   logic [1:0]        mode_code;
   op_mode_type       op_mode_r;
   op_mode_type       op_mode_nxt;
   logic              osc_en_r;
   logic              osc_en_nxt;
   logic              tx_en_r;
   logic              tx_en_nxt;
   logic              mod_data_r;
   logic              mod_data_nxt;
   synth_cfg_type     synth_r;
   synth_cfg_type     synth_nxt;
   rf_cfg_type        rf_r;
   rf_cfg_type        rf_nxt;

   // ------------------------------------------------------------------
   // link domain: the serial clock clocks only the shift register
   // ------------------------------------------------------------------
   frame_shifter u_frame_shifter (
      .serial_clk (SPI_CLOCK),
      .rst_n      (RSTN),
      .latch      (SPI_LATCH),
      .data_in    (SPI_DATA_IN), // see [RQ2]
      .word       (shift_word)
   );

   // ------------------------------------------------------------------
   // pin synchronisers into the system domain
   // ------------------------------------------------------------------
   assign pin_raw = {SPI_CLOCK, SPI_LATCH, MODE_PIN_HIGH, MODE_PIN_LOW,
                     ANALOG_STATUS.system_error, ANALOG_STATUS.battery_low,
                     ANALOG_STATUS.pll_locked, TX_DATA_IN};

   always_comb begin
      meta_nxt = pin_raw;
      sync_nxt = meta_r;
      // edge history reads only the second stage
      hist_nxt = {sync_r[IDX_SCLK], sync_r[IDX_LATCH]};
   end

   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         meta_r <= '0;
         sync_r <= '0;
         hist_r <= 2'h0;
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
         hist_r <= hist_nxt;
      end
   end

   assign sclk_lvl   = sync_r[IDX_SCLK];
   assign latch_lvl  = sync_r[IDX_LATCH];
   assign latch_rise = latch_lvl & ~hist_r[0];
   assign sclk_rise  = sclk_lvl & ~hist_r[1];

   // clock and latch high together is the reset condition, never a frame
   assign part_rst = sclk_lvl & latch_lvl; // see [RQ1]
   assign commit   = latch_rise & ~sclk_lvl; // see [RQ3]

   // the shifter is quiet while the latch is high, so the word is stable
   // by the time the synchronised latch edge arrives
   assign frame_word = shift_word;
   assign frame_addr = shift_word[ADDR_W-1:0]; // see [RQ26]

   // ------------------------------------------------------------------
   // register bank: one entry per address, only writable ones ever load
   // ------------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
         always_comb begin
            regs_nxt[gi] = regs_r[gi];
            if (commit && WRITABLE_MASK[gi] &&
                frame_addr == ADDR_W'(gi)) begin
               regs_nxt[gi] = frame_word; // see [RQ3] [RQ4]
            end
            if (gi == int'(ADDR_MODE) && part_rst) begin
               regs_nxt[gi] = regs_r[gi] & ~MODE_CLEAR_MASK; // see [RQ1]
            end
         end

         always_ff @(posedge SYS_CLK or negedge RSTN) begin
            if (!RSTN) begin
               regs_r[gi] <= REG_RESET;
            end else begin
               regs_r[gi] <= regs_nxt[gi];
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------------
   // status word
   // ------------------------------------------------------------------
   assign src_code = regs_r[ADDR_MODE][MODE_SRC_LSB +: 2];

   always_comb begin
      // source select: 10 error, 11 supply good, 0x lock
      case (src_code)
         SRC_ERROR:   status_sel = sync_r[IDX_ERR]; // see [RQ18] [RQ22]
         SRC_BATTERY: status_sel = ~sync_r[IDX_BATLO]; // see [RQ18] [RQ22]
         default:     status_sel = sync_r[IDX_LOCK]; // see [RQ18] [RQ22]
      endcase
      // don't-care bits read zero, address bits always zero
      status_word = '0; // see [RQ22]
      status_word[STATUS_SEL_BIT] = status_sel;
   end

   // ------------------------------------------------------------------
   // readback state machine
   // the next bit is driven a few system cycles after each synchronised
   // rising serial edge, so the serial period must exceed four system cycles
   // ------------------------------------------------------------------
   always_comb begin
      state_nxt     = state_r;
      bits_left_nxt = bits_left_r;
      status_sh_nxt = status_sh_r;
      case (state_r)
         PORT_WRITE: begin
            if (commit && frame_addr == ADDR_STATUS) begin
               state_nxt     = PORT_READ; // see [RQ5]
               status_sh_nxt = status_word[FRAME_W-1:STATUS_LSB];
               bits_left_nxt = STATUS_BITS;
            end
         end
         PORT_READ: begin
            if (commit) begin
               // a new frame ends the read; address zero starts a fresh one
               if (frame_addr == ADDR_STATUS) begin
                  status_sh_nxt = status_word[FRAME_W-1:STATUS_LSB]; // see [RQ5]
                  bits_left_nxt = STATUS_BITS;
               end else begin
                  state_nxt = PORT_WRITE;
               end
            end else if (sclk_rise) begin
               if (bits_left_r == 4'h1) begin
                  state_nxt     = PORT_WRITE; // see [RQ6]
                  bits_left_nxt = 4'h0;
               end else begin
                  status_sh_nxt = {status_sh_r[10:0], 1'b0};
                  bits_left_nxt = bits_left_r - 4'h1;
               end
            end
         end
         default: begin
            state_nxt     = PORT_WRITE;
            bits_left_nxt = 4'h0;
         end
      endcase

      // open drain: pull low only for a zero, release for a one
      oe_n_nxt     = ~((state_nxt == PORT_READ) & ~status_sh_nxt[11]); // see [RQ24]
      data_out_nxt = 1'b0; // see [RQ24]
   end

   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         state_r     <= PORT_WRITE;
         bits_left_r <= 4'h0;
         status_sh_r <= 12'h000;
         oe_n_r      <= 1'b1;
         data_out_r  <= 1'b0;
      end else begin
         state_r     <= state_nxt;
         bits_left_r <= bits_left_nxt;
         status_sh_r <= status_sh_nxt;
         oe_n_r      <= oe_n_nxt;
         data_out_r  <= data_out_nxt;
      end
   end

   // ------------------------------------------------------------------
   // configuration decode
   // ------------------------------------------------------------------
   always_comb begin
      synth_nxt.program_count =
         {regs_r[ADDR_SYNTH_HI][SH_PROG_LSB +: 3],
          regs_r[ADDR_SYNTH_LO][SL_PROG_LSB +: 7]}; // see [RQ7] [RQ8]
      synth_nxt.swallow_count = regs_r[ADDR_SYNTH_LO][SL_SWALLOW_LSB +: 5]; // see [RQ7]
      synth_nxt.ref_divider   = regs_r[ADDR_SYNTH_HI][SH_REF_LSB +: 8]; // see [RQ8]

      rf_nxt.data_polarity        = regs_r[ADDR_OSC][OSC_POL_BIT]; // see [RQ11]
      rf_nxt.tuning_window_select = regs_r[ADDR_VCO][VCO_WIN_LSB +: 3]; // see [RQ13]
      rf_nxt.output_power_select  = regs_r[ADDR_VCO][VCO_POWER_BIT]; // see [RQ14]
      // upper pump bit is reserved and ignored
      rf_nxt.pump_current_select  = regs_r[ADDR_VCO][VCO_PUMP_LSB +: 2]; // see [RQ15]
   end

   always_comb begin
      if (regs_r[ADDR_MODE][MODE_EXT_BIT]) begin
         mode_code = regs_r[ADDR_MODE][MODE_CODE_LSB +: 2]; // see [RQ20] [RQ21]
      end else begin
         mode_code = {sync_r[IDX_MHIGH], sync_r[IDX_MLOW]}; // see [RQ20] [RQ23]
      end

      op_mode_nxt = op_mode_type'(mode_code);
      // the reserved code is kept safe: everything off as in sleep
      case (op_mode_nxt)
         MODE_STANDBY: begin
            osc_en_nxt = 1'b1; // see [RQ21] [RQ23]
            tx_en_nxt  = 1'b0;
         end
         MODE_TRANSMIT: begin
            osc_en_nxt = 1'b1; // see [RQ21] [RQ23]
            tx_en_nxt  = 1'b1;
         end
         default: begin
            osc_en_nxt = 1'b0;
            tx_en_nxt  = 1'b0;
         end
      endcase

      // polarity zero inverts the transmit data
      mod_data_nxt = rf_r.data_polarity ? sync_r[IDX_TXD]
                                        : ~sync_r[IDX_TXD]; // see [RQ11]
   end

   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         synth_r    <= '0;
         rf_r       <= '0;
         op_mode_r  <= MODE_SLEEP;
         osc_en_r   <= 1'b0;
         tx_en_r    <= 1'b0;
         mod_data_r <= 1'b0;
      end else begin
         synth_r    <= synth_nxt;
         rf_r       <= rf_nxt;
         op_mode_r  <= op_mode_nxt;
         osc_en_r   <= osc_en_nxt;
         tx_en_r    <= tx_en_nxt;
         mod_data_r <= mod_data_nxt;
      end
   end

   // ------------------------------------------------------------------
   // outputs, all straight from flip-flops
   // ------------------------------------------------------------------
   assign SPI_DATA_OUT  = data_out_r;
   assign SPI_DATA_OE_N = oe_n_r;
   assign SYNTH_CFG     = synth_r;
   assign RF_CFG        = rf_r;
   assign OP_MODE       = op_mode_r;
   assign OSC_ENABLE    = osc_en_r;
   assign TX_ENABLE     = tx_en_r;
   assign MOD_DATA_OUT  = mod_data_r;

endmodule : config_port

/* File: testbench/config_port_sva.sv */
// concurrent checks on the configuration port outputs
`timescale 1ns/1ps
module config_port_sva (
   // system
   input  wire logic                   SYS_CLK,
   input  wire logic                   RSTN,
   // link and pins
   input  wire logic                   SPI_CLOCK,
   input  wire logic                   SPI_LATCH,
   input  wire logic                   SPI_DATA_OUT,
   input  wire logic                   MODE_PIN_HIGH,
   input  wire logic                   MODE_PIN_LOW,
   input  wire logic                   TX_DATA_IN,
   // watched outputs
   input  wire logic                   MOD_DATA_OUT,
   input  cfg_port_pkg::synth_cfg_type SYNTH_CFG,
   input  cfg_port_pkg::rf_cfg_type    RF_CFG,
   input  cfg_port_pkg::op_mode_type   OP_MODE,
   input  wire logic                   OSC_ENABLE,
   input  wire logic                   TX_ENABLE
);
   import cfg_port_pkg::*;
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RSTN);

   drive_zero_a: assert property (SPI_DATA_OUT == 1'b0)
      else $error("open drain line driven high");
   tx_enable_a: assert property (TX_ENABLE == (OP_MODE == MODE_TRANSMIT))
      else $error("transmit enable disagrees with mode");
   osc_enable_a: assert property (
      OSC_ENABLE == (OP_MODE inside {MODE_STANDBY, MODE_TRANSMIT}))
      else $error("oscillator enable disagrees with mode");
   polarity_path_a: assert property (
      ($stable(TX_DATA_IN) && $stable(RF_CFG))[*6]
      |-> MOD_DATA_OUT == (RF_CFG.data_polarity ? TX_DATA_IN : !TX_DATA_IN))
      else $error("modulation data polarity wrong");
   synth_hold_a: assert property ((!SPI_LATCH)[*8] |=> $stable(SYNTH_CFG))
      else $error("synthesizer setting changed without a frame");
   rf_hold_a: assert property ((!SPI_LATCH)[*8] |=> $stable(RF_CFG))
      else $error("rf setting changed without a frame");
   mode_hold_a: assert property (
      (!SPI_LATCH && $stable({MODE_PIN_HIGH, MODE_PIN_LOW}))[*8] |=> $stable(OP_MODE))
      else $error("mode changed without cause");
   partial_clear_a: assert property (
      (SPI_CLOCK && SPI_LATCH && $stable({MODE_PIN_HIGH, MODE_PIN_LOW}))[*8]
      |-> OP_MODE == op_mode_type'({MODE_PIN_HIGH, MODE_PIN_LOW}))
      else $error("partial reset did not hand mode to pins");
endmodule : config_port_sva

bind config_port config_port_sva u_sva (
   .SYS_CLK(SYS_CLK), .RSTN(RSTN), .SPI_CLOCK(SPI_CLOCK), .SPI_LATCH(SPI_LATCH),
   .SPI_DATA_OUT(SPI_DATA_OUT), .MODE_PIN_HIGH(MODE_PIN_HIGH), .MODE_PIN_LOW(MODE_PIN_LOW),
   .TX_DATA_IN(TX_DATA_IN), .MOD_DATA_OUT(MOD_DATA_OUT), .SYNTH_CFG(SYNTH_CFG),
   .RF_CFG(RF_CFG), .OP_MODE(OP_MODE), .OSC_ENABLE(OSC_ENABLE), .TX_ENABLE(TX_ENABLE)
);

/* File: testbench/link_ctrl.sv */
// baseband controller model driving the three-wire link
`timescale 1ns/1ps
module link_ctrl (
   // three-wire link
   output logic        clk_o,
   output logic        latch_o,
   output logic        data_o,
   output logic        data_en,
   input  wire logic   data_i
);
   logic [11:0] rd_bits;
   initial begin
      clk_o = 1'b0;
      latch_o = 1'b0;
      data_o = 1'b0;
      data_en = 1'b0;
   end
   // link clock runs at 30 ns inside a frame; status reads clock it at 60 ns
   task automatic send_frame(input logic [15:0] w);
      data_en = 1'b1;
      for (int i = 15; i >= 0; i--) begin
         #5 data_o = w[i];
         #10 clk_o = 1'b1;
         #15 clk_o = 1'b0;
      end
      data_en = 1'b0;
      #15 latch_o = 1'b1;
      #60 latch_o = 1'b0;
   endtask : send_frame
   // long low phase lets each status bit settle before it is sampled
   task automatic read_status();
      send_frame(16'h0000);
      for (int i = 11; i >= 0; i--) begin
         rd_bits[i] = data_i;
         #15 clk_o = 1'b1;
         #15 clk_o = 1'b0;
         #30;
      end
   endtask : read_status
   task automatic part_reset();
      clk_o = 1'b1;
      #60 latch_o = 1'b1;
      #1200 latch_o = 1'b0;
      #60 clk_o = 1'b0;
   endtask : part_reset
endmodule : link_ctrl

/* File: testbench/tb.sv */
// self-checking bench for the configuration port
`timescale 1ns/1ps
module tb;
   import cfg_port_pkg::*;
   logic              sys_clk = 1'b0;
   logic              rstn = 1'b0;
   logic              pin_h = 1'b0;
   logic              pin_l = 1'b0;
   logic              tx_in = 1'b0;
   analog_status_type ana = '0;
   logic              spi_clk, spi_lat, drv_d, drv_en, spi_out, oe_n, spi_wire;
   logic              mod_out, osc_en, tx_en, sr;
   synth_cfg_type     syn, e_syn;
   rf_cfg_type        rf, e_rf;
   op_mode_type       mode;
   logic [15:0]       mode_w;
   logic [9:0]        b;
   logic [4:0]        a;
   logic [7:0]        r;
   logic [31:0]       exp_q[$];
   logic [11:0]       rd_q[$];
   integer            seed = 32'h276f;
   int                n_mismatch = 0;
   int                check_count = 0;
   event              cfg_ev, rd_ev;

   always #4 sys_clk = ~sys_clk;
   always begin
      repeat (9) @(posedge sys_clk);
      tx_in <= ~tx_in;
   end
   // pulled-up wire: only the port's enable or the controller pull it
   assign spi_wire = (oe_n === 1'b0) ? spi_out : (drv_en ? drv_d : 1'b1);

   config_port u_config_port (
      .SYS_CLK(sys_clk), .RSTN(rstn), .SPI_CLOCK(spi_clk), .SPI_LATCH(spi_lat),
      .SPI_DATA_IN(spi_wire), .SPI_DATA_OUT(spi_out), .SPI_DATA_OE_N(oe_n),
      .MODE_PIN_HIGH(pin_h), .MODE_PIN_LOW(pin_l), .ANALOG_STATUS(ana),
      .TX_DATA_IN(tx_in), .MOD_DATA_OUT(mod_out), .SYNTH_CFG(syn), .RF_CFG(rf),
      .OP_MODE(mode), .OSC_ENABLE(osc_en), .TX_ENABLE(tx_en)
   );
   link_ctrl u_link (
      .clk_o(spi_clk), .latch_o(spi_lat), .data_o(drv_d), .data_en(drv_en), .data_i(spi_wire)
   );

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_of_test
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask : cmp
   // monitor: takes the oldest note whenever a result is announced
   always @(cfg_ev) cmp({syn, rf, mode}, exp_q.pop_front(), "config");
   always @(rd_ev) cmp({20'h0, u_link.rd_bits}, {20'h0, rd_q.pop_front()}, "status");

   task automatic expect_cfg();
      logic [1:0] c;
      repeat (10) @(posedge sys_clk);
      c = mode_w[6] ? mode_w[5:4] : {pin_h, pin_l};
      exp_q.push_back({e_syn, e_rf, c});
      -> cfg_ev;
   endtask : expect_cfg
   task automatic wr(input logic [15:0] w);
      u_link.send_frame(w);
      case (w[3:0])
         4'hf: {e_syn.program_count[6:0], e_syn.swallow_count} = w[15:4];
         4'h7: {e_syn.program_count[9:7], e_syn.ref_divider} = w[14:4];
         4'hb: e_rf.data_polarity = w[14];
         4'h3: e_rf[5:0] = {w[15:13], w[10], w[8:7]};
         4'h5: mode_w = w;
         default: ;
      endcase
      expect_cfg();
   endtask : wr
   task automatic oe_wait();
      int k;
      k = 0;
      while (oe_n !== 1'b1 && k < 8) begin
         @(posedge sys_clk);
         k++;
      end
      check_count++;
      if (oe_n !== 1'b1) begin
         n_mismatch++;
         $display("[FAIL] %0t data line not released", $time);
         end_of_test();
      end
   endtask : oe_wait

   initial begin
      e_syn = '0;
      e_rf = '0;
      mode_w = '0;
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge sys_clk);
      expect_cfg();
      $display("test reset values finished");
      for (int i = 0; i < 6; i++) begin
         b = 10'(33 + $unsigned($random(seed)) % 990);
         a = 5'($random(seed));
         r = 8'(2 + $unsigned($random(seed)) % 254);
         wr({b[6:0], a, 4'hf});
         wr({1'b0, b[9:7], r, 4'h7});
      end
      $display("test synthesizer finished");
      for (int p = 0; p < 2; p++) begin
         wr({1'b0, p[0], 10'h000, 4'hb});
         repeat (30) @(posedge sys_clk);
      end
      for (int v = 0; v < 8; v++)
         wr({v[2:0], 2'b00, v[0], 1'b0, v[2:1], 3'h4, 4'h3});
      wr(16'h3ffd);
      for (int k = 1; k < 15; k++)
         if (16'h5756 >> k & 16'h1) wr({12'($random(seed)), k[3:0]});
      $display("test settings finished");
      for (int m = 0; m < 4; m++)
         wr({10'h003, m[1:0], 4'h5});
      wr(16'h0085);
      for (int m = 0; m < 4; m++) begin
         pin_h <= m[1];
         pin_l <= m[0];
         expect_cfg();
      end
      $display("test modes finished");
      wr(16'h00e5);
      u_link.part_reset();
      mode_w[9:4] = 6'h00;
      expect_cfg();
      $display("test partial reset finished");
      for (int s = 0; s < 4; s++) begin
         // status pins change on a system clock edge, not at link time
         @(posedge sys_clk);
         ana <= analog_status_type'(3'($random(seed)));
         wr({5'h00, s[1:0], 9'h085});
         sr = s[1] ? (s[0] ? !ana.battery_low : ana.system_error) : ana.pll_locked;
         rd_q.push_back({9'h000, sr, 2'b00});
         u_link.read_status();
         -> rd_ev;
         oe_wait();
      end
      expect_cfg();
      $display("test status read finished");
      repeat (4) @(posedge sys_clk);
      end_of_test();
   end
endmodule : tb
